// ==== src/dac_defs.svh ====
// Encoding fields, opcodes, widths and step sizes of the compound-move executor
`ifndef DAC_DEFS_SVH
`define DAC_DEFS_SVH
`define DAC_ACC_W 36
`define DAC_ACC_MSB 35
`define DAC_WORD_W 16
`define DAC_GUARD_W 4
`define DAC_YREG_W 32
`define DAC_PAD_W 20
`define DAC_HI_MSB 31
`define DAC_HI_LSB 16
`define DAC_LO_MSB 15
`define DAC_B_D 10
`define DAC_B_S 9
`define DAC_F_HI 8
`define DAC_F_LO 5
`define DAC_B_X 4
`define DAC_B_SUB3 3
`define DAC_B_T 2
`define DAC_B_SUB1 1
`define DAC_B_SUB0 0
`define DAC_RM_HI 3
`define DAC_RM_LO 2
`define DAC_ZA_HI 1
`define DAC_ZA_LO 0
`define DAC_TOP_HI 15
`define DAC_TOP_LO 11
`define DAC_TOP_CAM 5'h05
`define DAC_TOP_CYX 5'h1D
`define DAC_TOP_ALU 5'h18
`define DAC_SUB_AA 4'h5
`define DAC_SUB_AP 5'h19
`define DAC_SUB_IMM 4'h1
`define DAC_F1_P_MPY 4'h0
`define DAC_F1_ADDP_MPY 4'h1
`define DAC_F1_MPY 4'h2
`define DAC_F1_SUBP_MPY 4'h3
`define DAC_F1_P 4'h4
`define DAC_F1_ADDP 4'h5
`define DAC_F1_NOP 4'h6
`define DAC_F1_SUBP 4'h7
`define DAC_F1_LDY 4'hC
`define DAC_OP_OR 4'h8
`define DAC_OP_XOR 4'h9
`define DAC_OP_TAND 4'hA
`define DAC_OP_TSUB 4'hB
`define DAC_OP_ADD 4'hD
`define DAC_OP_AND 4'hE
`define DAC_OP_SUB 4'hF
`define DAC_Z_ZP 2'h0
`define DAC_Z_PZ 2'h1
`define DAC_Z_M2 2'h2
`define DAC_Z_JK 2'h3
`define DAC_STEP_ONE 1
`define DAC_STEP_TWO 2
`endif

// ==== src/dac_pkg.sv ====
// Types shared by the compound-move executor and its arithmetic unit
package dac_pkg;
	typedef enum logic [2:0] {S_IDLE, S_YWAIT, S_YLOAD, S_YSTORE, S_XWAIT, S_XLOAD} dac_fsm_t;
	typedef enum logic [2:0] {K_NONE, K_CAM, K_CYX, K_AA, K_AP, K_IMM} dac_kind_t;
	typedef enum logic [2:0] {OP_PASS, OP_OR, OP_XOR, OP_AND, OP_ADD, OP_SUB} dac_alu_op_t;
	typedef struct packed {
		logic negative_flag;
		logic zero_flag;
		logic overflow_flag;
		logic math_overflow_flag;
	} dac_flags_t;
endpackage : dac_pkg

// ==== src/dac_alu_if.sv ====
// Operand and result bundle between the executor and the arithmetic unit
`timescale 1ns/1ns
`default_nettype none
interface dac_alu_if;
	import dac_pkg::*;
	dac_alu_op_t op;
	logic [35:0] opnd_a;
	logic [35:0] opnd_b;
	logic [35:0] result;
	dac_flags_t flags;
	modport client (output op, output opnd_a, output opnd_b, input result, input flags);
	modport unit (input op, input opnd_a, input opnd_b, output result, output flags);
endinterface : dac_alu_if
`default_nettype wire

// ==== src/dac_alu.sv ====
// 36-bit arithmetic unit of the compound-move executor
`timescale 1ns/1ns
`default_nettype none
`include "dac_defs.svh"
module dac_alu (
	dac_alu_if.unit alu // Operands in, result and flags out
);
	import dac_pkg::*;

	logic [35:0] res;
	logic sa;
	logic sb;
	logic sr;

	// Result, then flags from the full 36-bit value
	always_comb
	begin
		case (alu.op)
			OP_OR: res = alu.opnd_a | alu.opnd_b;
			OP_XOR: res = alu.opnd_a ^ alu.opnd_b;
			OP_AND: res = alu.opnd_a & alu.opnd_b;
			OP_ADD: res = alu.opnd_a + alu.opnd_b;
			OP_SUB: res = alu.opnd_a - alu.opnd_b;
			default: res = alu.opnd_b;
		endcase
		sa = alu.opnd_a[`DAC_ACC_MSB];
		sb = alu.opnd_b[`DAC_ACC_MSB];
		sr = res[`DAC_ACC_MSB];
		alu.result = res;
		alu.flags.negative_flag = sr;
		alu.flags.zero_flag = (res == '0);
		// Guard bits unequal to bit 31 means the value no longer fits 32 bits
		alu.flags.math_overflow_flag = !((&res[`DAC_ACC_MSB:`DAC_HI_MSB]) || !(|res[`DAC_ACC_MSB:`DAC_HI_MSB]));
		case (alu.op)
			OP_ADD: alu.flags.overflow_flag = (sa == sb) && (sr != sa);
			OP_SUB: alu.flags.overflow_flag = (sa != sb) && (sr != sa);
			default: alu.flags.overflow_flag = 1'b0;
		endcase
	end
endmodule : dac_alu
`default_nettype wire

// ==== src/dac_exec.sv ====
// Executor for compound-move multiply/ALU, accumulator and immediate ALU instructions
//
// Functional notes
// - D picks destination; transfer is the opposite
// - y sign-extended to 36 bits for operations
// - X picks transfer low half or full
// - Source equal to transfer uses old value
// - Z upper bits pick data pointer r0..r3
// - Save, load, update, store temp, update again
// - Z low bits pick both pointer updates
// - Code 11 adds j, then k
// - Multiply/ALU opcode selects product and y operations
// - Data move always swaps the full y
// - Table pointer word loads x, mapped memory
// - Table pointer advances by one or i
// - ALU-only opcode decode; other codes reserved
// - Flag-only AND/subtract leave accumulators alone
// - Destination and two sources chosen independently
// - Product sign-extended to 36 bits
// - ALU-only product add/subtract equal multiply/ALU forms
// - Immediate extended to 36, full-width result
// - Field zero selects a0, one a1
// - Only four flags updated from result
// - Single-cycle accumulator forms interruptible and cacheable
// - High immediate: bits 31-16, sign guards, zero low (ones low for AND)
`timescale 1ns/1ns
`default_nettype none
`include "dac_defs.svh"
module dac_exec #(
	parameter int ADDR_W = 16 // Pointer and memory address width
) (
	input wire logic clk, // Processor clock, 20 MHz
	input wire logic reset_n, // Asynchronous reset, active low
	input wire logic instr_valid, // Instruction word offered
	input wire logic [15:0] instr_word, // Instruction word
	input wire logic [15:0] immediate_word, // Second word of immediate forms
	input wire logic [ADDR_W-1:0] j_step, // j register
	input wire logic [ADDR_W-1:0] k_step, // k register
	input wire logic [ADDR_W-1:0] i_step, // i register
	input wire logic x_map_ext, // Memory map puts X word external
	input wire logic [15:0] y_mem_rdata, // Y-space read data, cycle after strobe
	input wire logic [15:0] x_mem_rdata, // X-space read data, cycle after strobe
	output logic instr_ready, // Idle, next instruction taken
	output logic instr_done, // Instruction retired pulse
	output logic reserved_op, // Last instruction was reserved
	output logic interruptible, // Last instruction interruptible
	output logic cacheable, // Last instruction cacheable
	output logic y_mem_rd, // Y-space read strobe
	output logic y_mem_wr, // Y-space write strobe
	output logic [ADDR_W-1:0] y_mem_addr, // Y-space address
	output logic [15:0] y_mem_wdata, // Y-space write data
	output logic x_mem_rd, // X-space read strobe
	output logic [ADDR_W-1:0] x_mem_addr, // X-space address
	output logic x_mem_ext, // X read goes to external memory
	output logic [35:0] acc0, // Accumulator a0
	output logic [35:0] acc1, // Accumulator a1
	output logic [15:0] x_value, // x register
	output logic [31:0] y_value, // y register
	output logic [31:0] p_value, // Product register
	output logic [3:0][ADDR_W-1:0] data_pointer_reg, // r0..r3
	output logic [ADDR_W-1:0] table_pointer, // Table pointer
	output var dac_pkg::dac_flags_t status_flags // Condition flags
);
	import dac_pkg::*;

	// Narrow pointers cannot address memory; wide ones exceed the data word
	if (ADDR_W < 4 || ADDR_W > 16)
	begin : g_chk
		$error("dac_exec: ADDR_W must be 4 to 16");
	end

	typedef struct packed {
		dac_fsm_t fsm;
		dac_kind_t kind;
		logic [35:0] a0;
		logic [35:0] a1;
		logic [15:0] x;
		logic [31:0] y;
		logic [31:0] p;
		logic [3:0][ADDR_W-1:0] r;
		logic [ADDR_W-1:0] pt;
		dac_flags_t flags;
		logic [1:0] rsel;
		logic [1:0] zact;
		logic xsel;
		logic t_a1;
		logic [15:0] temp;
		logic y_rd;
		logic y_wr;
		logic [ADDR_W-1:0] y_addr;
		logic [15:0] y_wdata;
		logic x_rd;
		logic [ADDR_W-1:0] x_addr;
		logic x_ext;
		logic busy;
		logic done;
		logic rsvd;
		logic intr;
		logic cach;
	} dac_regs_t;

	dac_regs_t st_reg;
	dac_regs_t st_next;
	dac_alu_if alu_bus ();

	logic accept;
	logic [3:0] fop;
	logic bit_d;
	logic bit_s;
	logic bit_x;
	dac_kind_t dec_kind;
	logic [35:0] src_acc;
	logic [35:0] y_ext;
	logic [35:0] p_ext;
	logic [35:0] imm_ext;
	logic [31:0] prod;
	logic wr_acc;
	logic wr_flags;
	logic wr_p;
	logic is_rsvd;
	logic [ADDR_W-1:0] cur_ptr;

	dac_alu u_alu (
		.alu(alu_bus)
	);

	// Pointer post-modify; first and second actions share one code
	function automatic logic [ADDR_W-1:0] ptr_step(input logic [ADDR_W-1:0] ptr, input logic [1:0] code,
		input logic second, input logic [ADDR_W-1:0] jv, input logic [ADDR_W-1:0] kv);
		logic [ADDR_W-1:0] one;
		logic [ADDR_W-1:0] two;
		one = ADDR_W'(`DAC_STEP_ONE);
		two = ADDR_W'(`DAC_STEP_TWO);
		case (code)
			`DAC_Z_ZP: ptr_step = second ? ptr + one : ptr;
			`DAC_Z_PZ: ptr_step = second ? ptr : ptr + one;
			`DAC_Z_M2: ptr_step = second ? ptr + two : ptr - one;
			default: ptr_step = second ? ptr + kv : ptr + jv;
		endcase
	endfunction : ptr_step

	assign accept = instr_valid && !st_reg.busy;
	assign fop = instr_word[`DAC_F_HI:`DAC_F_LO];
	assign bit_d = instr_word[`DAC_B_D];
	assign bit_s = instr_word[`DAC_B_S];
	assign bit_x = instr_word[`DAC_B_X];
	assign src_acc = bit_s ? st_reg.a1 : st_reg.a0;
	assign y_ext = {{`DAC_GUARD_W{st_reg.y[`DAC_HI_MSB]}}, st_reg.y};
	assign p_ext = {{`DAC_GUARD_W{st_reg.p[`DAC_HI_MSB]}}, st_reg.p};
	assign prod = 32'($signed(st_reg.x) * $signed(st_reg.y[`DAC_HI_MSB:`DAC_HI_LSB]));
	assign cur_ptr = st_reg.r[st_reg.rsel];

	// Instruction class from the top five bits and the low sub-field
	always_comb
	begin
		dec_kind = K_NONE;
		case (instr_word[`DAC_TOP_HI:`DAC_TOP_LO])
			`DAC_TOP_CAM: dec_kind = K_CAM;
			`DAC_TOP_CYX: dec_kind = K_CYX;
			`DAC_TOP_ALU:
			begin
				if (instr_word[`DAC_B_X:`DAC_B_SUB0] == `DAC_SUB_AP)
					dec_kind = K_AP;
				else if ({instr_word[`DAC_B_X:`DAC_B_SUB3], instr_word[`DAC_B_SUB1:`DAC_B_SUB0]} == `DAC_SUB_AA)
					dec_kind = K_AA;
				else if (instr_word[`DAC_B_SUB3:`DAC_B_SUB0] == `DAC_SUB_IMM)
					dec_kind = K_IMM;
			end
			default: dec_kind = K_NONE;
		endcase
	end

	// Immediate padding: AND pads with ones so two halves chain to 32 bits
	always_comb
	begin
		if (bit_x)
			imm_ext = {{`DAC_GUARD_W{immediate_word[`DAC_LO_MSB]}}, immediate_word,
				(fop == `DAC_OP_AND || fop == `DAC_OP_TAND) ? {`DAC_WORD_W{1'b1}} : {`DAC_WORD_W{1'b0}}};
		else
			imm_ext = {(fop == `DAC_OP_AND || fop == `DAC_OP_TAND) ? {`DAC_PAD_W{1'b1}} : {`DAC_PAD_W{1'b0}},
				immediate_word};
	end

	// Operation select; all operands read pre-instruction register values
	always_comb
	begin
		alu_bus.op = OP_PASS;
		alu_bus.opnd_a = src_acc;
		alu_bus.opnd_b = y_ext;
		wr_acc = 1'b0;
		wr_flags = 1'b0;
		wr_p = 1'b0;
		is_rsvd = 1'b0;
		if (dec_kind == K_CAM || dec_kind == K_CYX)
		begin
			wr_acc = 1'b1;
			wr_flags = 1'b1;
			case (fop)
				`DAC_F1_P_MPY, `DAC_F1_P: alu_bus.opnd_b = p_ext;
				`DAC_F1_ADDP_MPY, `DAC_F1_ADDP:
				begin
					alu_bus.op = OP_ADD;
					alu_bus.opnd_b = p_ext;
				end
				`DAC_F1_SUBP_MPY, `DAC_F1_SUBP:
				begin
					alu_bus.op = OP_SUB;
					alu_bus.opnd_b = p_ext;
				end
				`DAC_F1_MPY, `DAC_F1_NOP:
				begin
					wr_acc = 1'b0;
					wr_flags = 1'b0;
				end
				`DAC_F1_LDY: alu_bus.op = OP_PASS;
				`DAC_OP_OR: alu_bus.op = OP_OR;
				`DAC_OP_XOR: alu_bus.op = OP_XOR;
				`DAC_OP_TAND, `DAC_OP_AND: alu_bus.op = OP_AND;
				default: alu_bus.op = (fop == `DAC_OP_ADD) ? OP_ADD : OP_SUB;
			endcase
			if (fop == `DAC_OP_TAND || fop == `DAC_OP_TSUB)
				wr_acc = 1'b0;
			wr_p = (fop <= `DAC_F1_SUBP_MPY);
		end
		else if (dec_kind == K_AA || dec_kind == K_AP || dec_kind == K_IMM)
		begin
			case (dec_kind)
				K_AA: alu_bus.opnd_b = instr_word[`DAC_B_T] ? st_reg.a1 : st_reg.a0;
				K_AP: alu_bus.opnd_b = p_ext;
				default: alu_bus.opnd_b = imm_ext;
			endcase
			wr_acc = 1'b1;
			wr_flags = 1'b1;
			case (fop)
				`DAC_OP_OR: alu_bus.op = OP_OR;
				`DAC_OP_XOR: alu_bus.op = OP_XOR;
				`DAC_OP_TAND, `DAC_OP_AND: alu_bus.op = OP_AND;
				`DAC_OP_TSUB, `DAC_OP_SUB: alu_bus.op = OP_SUB;
				`DAC_OP_ADD: alu_bus.op = OP_ADD;
				default:
				begin
					is_rsvd = 1'b1;
					wr_acc = 1'b0;
					wr_flags = 1'b0;
				end
			endcase
			if (fop == `DAC_OP_TAND || fop == `DAC_OP_TSUB)
				wr_acc = 1'b0;
		end
	end

	// Sequencer: ALU commit at accept, then the memory half of the move
	always_comb
	begin
		st_next = st_reg;
		st_next.y_rd = 1'b0;
		st_next.y_wr = 1'b0;
		st_next.x_rd = 1'b0;
		st_next.done = 1'b0;
		case (st_reg.fsm)
			S_IDLE:
			begin
				if (accept)
				begin
					st_next.kind = dec_kind;
					st_next.rsvd = is_rsvd;
					st_next.intr = (dec_kind == K_AA || dec_kind == K_AP || dec_kind == K_IMM);
					st_next.cach = (dec_kind == K_AA || dec_kind == K_AP);
					if (wr_acc && bit_d)
						st_next.a1 = alu_bus.result;
					else if (wr_acc)
						st_next.a0 = alu_bus.result;
					if (wr_flags)
						st_next.flags = alu_bus.flags;
					if (wr_p)
						st_next.p = prod;
					if (dec_kind == K_CAM || dec_kind == K_CYX)
					begin
						st_next.rsel = instr_word[`DAC_RM_HI:`DAC_RM_LO];
						st_next.zact = instr_word[`DAC_ZA_HI:`DAC_ZA_LO];
						st_next.xsel = bit_x;
						st_next.t_a1 = !bit_d;
						// Temp is taken from the old value, before the load lands
						if (dec_kind == K_CYX)
							st_next.temp = st_reg.y[`DAC_HI_MSB:`DAC_HI_LSB];
						else if (bit_x)
							st_next.temp = bit_d ? st_reg.a0[`DAC_HI_MSB:`DAC_HI_LSB] : st_reg.a1[`DAC_HI_MSB:`DAC_HI_LSB];
						else
							st_next.temp = bit_d ? st_reg.a0[`DAC_LO_MSB:0] : st_reg.a1[`DAC_LO_MSB:0];
						st_next.y_rd = 1'b1;
						st_next.y_addr = st_reg.r[instr_word[`DAC_RM_HI:`DAC_RM_LO]];
						st_next.busy = 1'b1;
						st_next.fsm = S_YWAIT;
					end
					else
						st_next.done = 1'b1;
				end
			end
			S_YWAIT: st_next.fsm = S_YLOAD;
			S_YLOAD:
			begin
				if (st_reg.kind == K_CYX)
					st_next.y = {y_mem_rdata, {`DAC_WORD_W{1'b0}}};
				else if (st_reg.xsel && st_reg.t_a1)
					st_next.a1 = {{`DAC_GUARD_W{y_mem_rdata[`DAC_LO_MSB]}}, y_mem_rdata, {`DAC_WORD_W{1'b0}}};
				else if (st_reg.xsel)
					st_next.a0 = {{`DAC_GUARD_W{y_mem_rdata[`DAC_LO_MSB]}}, y_mem_rdata, {`DAC_WORD_W{1'b0}}};
				else if (st_reg.t_a1)
					st_next.a1[`DAC_LO_MSB:0] = y_mem_rdata;
				else
					st_next.a0[`DAC_LO_MSB:0] = y_mem_rdata;
				st_next.r[st_reg.rsel] = ptr_step(cur_ptr, st_reg.zact, 1'b0, j_step, k_step);
				st_next.y_wr = 1'b1;
				st_next.y_addr = ptr_step(cur_ptr, st_reg.zact, 1'b0, j_step, k_step);
				st_next.y_wdata = st_reg.temp;
				st_next.fsm = S_YSTORE;
			end
			S_YSTORE:
			begin
				st_next.r[st_reg.rsel] = ptr_step(cur_ptr, st_reg.zact, 1'b1, j_step, k_step);
				if (st_reg.kind == K_CYX)
				begin
					st_next.x_rd = 1'b1;
					st_next.x_addr = st_reg.pt;
					st_next.x_ext = x_map_ext;
					st_next.fsm = S_XWAIT;
				end
				else
				begin
					st_next.done = 1'b1;
					st_next.busy = 1'b0;
					st_next.fsm = S_IDLE;
				end
			end
			S_XWAIT: st_next.fsm = S_XLOAD;
			S_XLOAD:
			begin
				st_next.x = x_mem_rdata;
				st_next.pt = st_reg.pt + (st_reg.xsel ? i_step : ADDR_W'(`DAC_STEP_ONE));
				st_next.done = 1'b1;
				st_next.busy = 1'b0;
				st_next.fsm = S_IDLE;
			end
			default:
			begin
				st_next.busy = 1'b0;
				st_next.fsm = S_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	// Outputs straight from the state register
	assign instr_ready = !st_reg.busy;
	assign instr_done = st_reg.done;
	assign reserved_op = st_reg.rsvd;
	assign interruptible = st_reg.intr;
	assign cacheable = st_reg.cach;
	assign y_mem_rd = st_reg.y_rd;
	assign y_mem_wr = st_reg.y_wr;
	assign y_mem_addr = st_reg.y_addr;
	assign y_mem_wdata = st_reg.y_wdata;
	assign x_mem_rd = st_reg.x_rd;
	assign x_mem_addr = st_reg.x_addr;
	assign x_mem_ext = st_reg.x_ext;
	assign acc0 = st_reg.a0;
	assign acc1 = st_reg.a1;
	assign x_value = st_reg.x;
	assign y_value = st_reg.y;
	assign p_value = st_reg.p;
	assign data_pointer_reg = st_reg.r;
	assign table_pointer = st_reg.pt;
	assign status_flags = st_reg.flags;

	// Checks on the sequencer and the datapath
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	chk_cam_transfer: assert property (
		accept && dec_kind == K_CAM && !bit_d && !bit_x
		|-> ##3 (y_mem_wr && y_mem_wdata == $past(st_reg.a1[15:0], 3)))
		else $error("transfer low half of a1 not stored");
	chk_y_sext_or: assert property (
		accept && dec_kind == K_CYX && fop == 4'h8 && !bit_s && bit_d
		|=> acc1 == $past(st_reg.a0 | y_ext))
		else $error("OR with sign-extended y wrong");
	chk_old_source: assert property (
		accept && dec_kind == K_CAM && !bit_d && bit_s && fop == 4'h5
		|=> acc0 == $past(st_reg.a1 + p_ext))
		else $error("source did not use pre-instruction value");
	chk_ptr_select: assert property (
		accept && (dec_kind == K_CAM || dec_kind == K_CYX)
		|=> y_mem_rd && y_mem_addr == $past(st_reg.r[instr_word[3:2]]))
		else $error("wrong data pointer used");
	chk_jk_update: assert property (
		accept && (dec_kind == K_CAM || dec_kind == K_CYX) && instr_word[3:0] == 4'h3
		|-> ##4 data_pointer_reg[0] == $past(st_reg.r[0], 4) + $past(j_step, 2) + $past(k_step, 1))
		else $error("j then k pointer update wrong");
	chk_full_y_swap: assert property (
		accept && dec_kind == K_CYX
		|-> ##3 (y_mem_wr && y_mem_wdata == $past(st_reg.y[31:16], 3)))
		else $error("full y not swapped through temp");
	chk_x_load: assert property (
		accept && dec_kind == K_CYX && bit_x
		|-> ##4 (x_mem_rd && x_mem_addr == $past(st_reg.pt, 4)) ##2
		(x_value == $past(x_mem_rdata, 1) && table_pointer == $past(st_reg.pt, 6) + $past(i_step, 1)))
		else $error("x load or table pointer advance wrong");
	chk_flag_only: assert property (
		accept && dec_kind == K_AA && (fop == 4'hA || fop == 4'hB)
		|=> acc0 == $past(st_reg.a0) && acc1 == $past(st_reg.a1))
		else $error("flag-only op changed an accumulator");
	chk_imm_high: assert property (
		accept && dec_kind == K_IMM && bit_x && fop == 4'hD && !bit_s && !bit_d
		|=> acc0 == $past(st_reg.a0 + {{4{immediate_word[15]}}, immediate_word, 16'h0000}))
		else $error("high immediate add misaligned");
	chk_reserved_op: assert property (
		accept && (dec_kind == K_AA || dec_kind == K_AP) && is_rsvd
		|=> reserved_op && $stable(status_flags) && $stable(acc0) && $stable(acc1))
		else $error("reserved opcode altered state");
	chk_single_cycle: assert property (
		accept && (dec_kind == K_AA || dec_kind == K_AP)
		|=> instr_done && interruptible && cacheable && instr_ready)
		else $error("accumulator op not single-cycle cacheable");
endmodule : dac_exec
`default_nettype wire

// ==== sim/dac_mem_model.sv ====
// Behavioural X-space and Y-space data memory beside the executor
`timescale 1ns/1ns
`default_nettype none
module dac_mem_model #(
	parameter int ADDR_W = 8 // Address width
) (
	input wire logic clk, // Processor clock
	input wire logic y_mem_rd, // Y read strobe
	input wire logic y_mem_wr, // Y write strobe
	input wire logic [ADDR_W-1:0] y_mem_addr, // Y address
	input wire logic [15:0] y_mem_wdata, // Y write data
	output logic [15:0] y_mem_rdata, // Y read data
	input wire logic x_mem_rd, // X read strobe
	input wire logic [ADDR_W-1:0] x_mem_addr, // X address
	input wire logic x_mem_ext, // X read goes external
	output logic [15:0] x_mem_rdata // X read data
);
	logic [15:0] ymem [2**ADDR_W];
	logic [15:0] xint [2**ADDR_W];
	logic [15:0] xext [2**ADDR_W];
	// One-cycle read latency; between reads the data toggles so a late sample shows up
	always @(posedge clk)
	begin
		if (y_mem_wr)
			ymem[y_mem_addr] <= y_mem_wdata;
		y_mem_rdata <= y_mem_rd ? ymem[y_mem_addr] : ~y_mem_rdata;
		x_mem_rdata <= x_mem_rd ? (x_mem_ext ? xext[x_mem_addr] : xint[x_mem_addr]) : ~x_mem_rdata;
	end
endmodule : dac_mem_model
`default_nettype wire

// ==== sim/test_dsp_alu_compound_move_exec.sv ====
// Self-checking testbench of the compound-move executor
`timescale 1ns/1ns
`default_nettype none
module test_dsp_alu_compound_move_exec;
	import dac_pkg::*;
	localparam logic [15:0] YA = 16'h9234;
	localparam logic [15:0] YB = 16'h0ACE;
	localparam logic [15:0] YC = 16'h7531;
	localparam logic [15:0] XA = 16'h0003;
	localparam logic [15:0] XB = 16'hC001;
	logic clk, reset_n, instr_valid, x_map_ext;
	logic [15:0] instr_word, immediate_word, y_mem_wdata, y_mem_rdata, x_mem_rdata, x_value;
	logic [7:0] j_step, k_step, i_step, y_mem_addr, x_mem_addr, table_pointer;
	logic instr_ready, instr_done, reserved_op, interruptible, cacheable, y_mem_rd, y_mem_wr, x_mem_rd, x_mem_ext;
	logic [35:0] acc0, acc1, e0, e1;
	logic [31:0] y_value, p_value, pe;
	logic [3:0][7:0] data_pointer_reg;
	dac_flags_t status_flags;
	logic [3:0] ef;
	logic [39:0] rf;
	int err_total, total_checks;

	dac_exec #(.ADDR_W(8)) u_dac_exec (.clk, .reset_n, .instr_valid, .instr_word, .immediate_word, .j_step,
		.k_step, .i_step, .x_map_ext, .y_mem_rdata, .x_mem_rdata, .instr_ready, .instr_done, .reserved_op,
		.interruptible, .cacheable, .y_mem_rd, .y_mem_wr, .y_mem_addr, .y_mem_wdata, .x_mem_rd, .x_mem_addr,
		.x_mem_ext, .acc0, .acc1, .x_value, .y_value, .p_value, .data_pointer_reg, .table_pointer, .status_flags);
	dac_mem_model #(.ADDR_W(8)) u_dac_mem_model (.clk, .y_mem_rd, .y_mem_wr, .y_mem_addr, .y_mem_wdata,
		.y_mem_rdata, .x_mem_rd, .x_mem_addr, .x_mem_ext, .x_mem_rdata);

	// 20 MHz clock
	always #25 clk = ~clk;

	task end_of_test;
		if (err_total == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test

	task chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// Reference result and flags {neg, zero, ovf, mov}; plain pass for the load code
	function automatic logic [39:0] ref_alu(input logic [3:0] f, input logic [35:0] a, input logic [35:0] b);
		logic [35:0] r;
		logic v;
		v = 1'h0;
		case (f)
			4'h8: r = a | b;
			4'h9: r = a ^ b;
			4'hA, 4'hE: r = a & b;
			4'hD:
			begin
				r = a + b;
				v = (a[35] == b[35]) && (r[35] != a[35]);
			end
			4'hB, 4'hF:
			begin
				r = a - b;
				v = (a[35] != b[35]) && (r[35] != a[35]);
			end
			default: r = b;
		endcase
		return {r[35], r == 36'h0, v, !(&r[35:31] || !(|r[35:31])), r};
	endfunction : ref_alu

	function automatic logic [15:0] enc(input logic [4:0] t, input logic d, input logic s, input logic [3:0] f,
		input logic x, input logic [3:0] z);
		return {t, d, s, f, x, z};
	endfunction : enc

	// One instruction, then a bounded wait for its retire pulse
	task run(input logic [15:0] w, input logic [15:0] im);
		int n;
		@(negedge clk);
		instr_valid = 1'h1;
		instr_word = w;
		immediate_word = im;
		@(negedge clk);
		instr_valid = 1'h0;
		n = 0;
		while (instr_done !== 1'h1 && n < 20)
		begin
			@(negedge clk);
			n++;
		end
		if (n == 20)
		begin
			err_total++;
			end_of_test();
		end
	endtask : run

	task s_reset;
		repeat (5) @(negedge clk);
		reset_n = 1'h1;
		chk("ready", instr_ready, 1'h1);
		chk("acc0", acc0, 36'h0);
	endtask : s_reset

	// Y swap through r0 with j/k steps, again with +1 and an external x word, then an OR with y
	task s_ymove;
		run(enc(5'h1D, 1'h0, 1'h0, 4'h6, 1'h0, 4'h3), 16'h0);
		chk("y", y_value, {YA, 16'h0});
		chk("x", x_value, XA);
		chk("pt", table_pointer, 8'h01);
		chk("r0", data_pointer_reg[0], 8'h08);
		chk("temp", u_dac_mem_model.ymem[3], 16'h0);
		x_map_ext = 1'h1;
		run(enc(5'h1D, 1'h0, 1'h0, 4'h2, 1'h1, 4'h1), 16'h0);
		pe = $signed(XA) * $signed(YA);
		chk("y2", y_value, {YB, 16'h0});
		chk("x2", x_value, XB);
		chk("pt2", table_pointer, 8'h08);
		chk("r0b", data_pointer_reg[0], 8'h09);
		chk("temp2", u_dac_mem_model.ymem[9], YA);
		chk("p", p_value, pe);
		run(enc(5'h1D, 1'h1, 1'h0, 4'h8, 1'h0, 4'h0), 16'h0);
		chk("a1or", acc1, {4'h0, YB, 16'h0});
		chk("temp3", u_dac_mem_model.ymem[9], YB);
		chk("r0c", data_pointer_reg[0], 8'h0A);
		chk("x3", x_value, XA);
		chk("pt3", table_pointer, 8'h09);
	endtask : s_ymove

	// Full load of a1 via r2 with -1/+2, then low half with source equal to transfer
	task s_acc;
		run(enc(5'h05, 1'h0, 1'h0, 4'h6, 1'h1, 4'hA), 16'h0);
		e1 = {{4{YA[15]}}, YA, 16'h0};
		chk("a1", acc1, e1);
		chk("r2", data_pointer_reg[2], 8'h01);
		chk("temp", u_dac_mem_model.ymem[8'hFF], YB);
		run(enc(5'h05, 1'h0, 1'h1, 4'h5, 1'h0, 4'h8), 16'h0);
		rf = ref_alu(4'hD, e1, {{4{pe[31]}}, pe});
		e0 = rf[35:0];
		ef = rf[39:36];
		e1 = {e1[35:16], YC};
		chk("a0", acc0, e0);
		chk("a1low", acc1, e1);
		chk("flags", status_flags, ef);
		chk("temp2", u_dac_mem_model.ymem[1], 16'h0);
		chk("r2b", data_pointer_reg[2], 8'h02);
	endtask : s_acc

	// Every ALU-only code, fields D, S, T varied independently
	task s_aa;
		for (int f = 0; f < 16; f++)
		begin
			run({5'h18, f[0], f[1], f[3:0], 2'h1, f[2], 2'h1}, 16'h0);
			rf = ref_alu(f[3:0], f[1] ? e1 : e0, f[2] ? e1 : e0);
			if (f[3] && f != 12)
			begin
				ef = rf[39:36];
				if (f != 10 && f != 11)
				begin
					if (f[0])
						e1 = rf[35:0];
					else
						e0 = rf[35:0];
				end
			end
			chk("reserved", reserved_op, !(f[3] && f != 12));
			chk("a0", acc0, e0);
			chk("a1", acc1, e1);
			chk("flags", status_flags, ef);
			chk("cache", cacheable, 1'h1);
		end
	endtask : s_aa

	task s_ap;
		run({5'h18, 1'h1, 1'h0, 4'hF, 5'h19}, 16'h0);
		rf = ref_alu(4'hF, e0, {{4{pe[31]}}, pe});
		e1 = rf[35:0];
		chk("a1", acc1, e1);
		chk("flags", status_flags, rf[39:36]);
		chk("intr", interruptible, 1'h1);
		chk("cache", cacheable, 1'h1);
	endtask : s_ap

	// High add with a negative word, then low AND padded with ones
	task s_imm;
		run({5'h18, 1'h0, 1'h0, 4'hD, 1'h1, 4'h1}, 16'h8000);
		rf = ref_alu(4'hD, e0, {4'hF, 16'h8000, 16'h0});
		e0 = rf[35:0];
		chk("a0", acc0, e0);
		chk("flags", status_flags, rf[39:36]);
		chk("cache", cacheable, 1'h0);
		run({5'h18, 1'h1, 1'h0, 4'hE, 1'h0, 4'h1}, 16'h1234);
		rf = ref_alu(4'hE, e0, {20'hFFFFF, 16'h1234});
		chk("a1", acc1, rf[35:0]);
		chk("intr", interruptible, 1'h1);
	endtask : s_imm

	// Start values, memory contents, then the scenarios in order
	initial
	begin
		clk = 1'h0;
		reset_n = 1'h0;
		instr_valid = 1'h0;
		instr_word = 16'h0;
		immediate_word = 16'h0;
		j_step = 8'h03;
		k_step = 8'h05;
		i_step = 8'h07;
		x_map_ext = 1'h0;
		err_total = 0;
		total_checks = 0;
		u_dac_mem_model.ymem[0] = YA;
		u_dac_mem_model.ymem[8] = YB;
		u_dac_mem_model.ymem[1] = YC;
		u_dac_mem_model.xint[0] = XA;
		u_dac_mem_model.xint[1] = 16'h5A5A;
		u_dac_mem_model.xext[1] = XB;
		u_dac_mem_model.xext[8] = XA;
		s_reset();
		s_ymove();
		s_acc();
		s_aa();
		s_ap();
		s_imm();
		end_of_test();
	end
endmodule : test_dsp_alu_compound_move_exec
`default_nettype wire
